// ### bgp_pkg.sv
// shared constants for the bridge gate protection block
package bgp_pkg;
    // register map (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    // control field positions
    localparam int CTRL_DEAD_LSB = 0;
    localparam int CTRL_RECH_LSB = 8;
    // status field positions
    localparam int ST_OC_LSB = 0;
    localparam int ST_THERM = 4;
    localparam int ST_SUPPLY = 5;
    localparam int ST_WARN = 6;
    localparam int ST_READY = 7;
    localparam int ST_MODE_LSB = 8;
    localparam int ST_CBC_LSB = 12;
    localparam int ST_RECH_LSB = 16;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PWM_REF_HZ = 10000;
    localparam int MIN_OFF_NS = 20;
    localparam int LS_MIN_ON_NS = 50;
    localparam int PWM_REF_PERIOD_NS = 1000000000 / PWM_REF_HZ;
    // longest on time before forced recharge, rounded down
    localparam int MAX_ON_CYCLES = (PWM_REF_PERIOD_NS - MIN_OFF_NS) / CLK_PERIOD_NS;
    // least recharge pulse, rounded up
    localparam int RECH_CYCLES = (LS_MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_CYCLES = 2;
    // reset values
    localparam logic [7:0] DEAD_RST = 8'(DEAD_CYCLES);
    localparam logic [7:0] RECH_RST = 8'(RECH_CYCLES);
    // operating modes as strapped
    typedef enum logic [1:0] {
        BGP_MODE_INDEP_CBC = 2'h0,
        BGP_MODE_INDEP_LATCH = 2'h1,
        BGP_MODE_PARALLEL = 2'h2,
        BGP_MODE_SINGLE = 2'h3
    } bgp_mode_t;
endpackage

// ### bgp_half_bridge.sv
// one half bridge gate stage with break-before-make
`timescale 1ns/1ps
`default_nettype none
module bgp_half_bridge (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // requested gate state, never both
    input wire logic want_hs_i,
    input wire logic want_ls_i,
    input wire logic [7:0] dead_i,
    // gate drive
    output logic hs_o,
    output logic ls_o
);
    logic [7:0] dead_cnt;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hs_o <= 1'b0;
            ls_o <= 1'b0;
            dead_cnt <= 8'h00;
        end else if ((hs_o && !want_hs_i) || (ls_o && !want_ls_i)) begin
            // turn-off is immediate, turn-on waits out the gap
            hs_o <= 1'b0;
            ls_o <= 1'b0;
            dead_cnt <= dead_i;
        end else if (dead_cnt != 8'h00) begin
            dead_cnt <= dead_cnt - 8'h01;
        end else begin
            hs_o <= want_hs_i && !want_ls_i;
            ls_o <= want_ls_i && !want_hs_i;
        end
    end
endmodule
`default_nettype wire

// ### bgp_ctrl.sv
// four half bridge gate control, protection and register slave
`timescale 1ns/1ps
`default_nettype none
module bgp_ctrl #(
    parameter int NUM_HB = 4,
    parameter int MAX_ON = bgp_pkg::MAX_ON_CYCLES
) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    // controller side
    input wire logic [3:0] PWM_I,
    input wire logic PAIR_ONE_RESET_N_I,
    input wire logic PAIR_TWO_RESET_N_I,
    input wire logic [1:0] MODE_I,
    output logic FAULT_N_O,
    output logic THERMAL_WARNING_N_O,
    // comparator inputs
    input wire logic [3:0] OC_HS_I,
    input wire logic [3:0] OC_LS_I,
    input wire logic [3:0] SHORT_I,
    input wire logic [3:0] BOOTSTRAP_LOW_I,
    input wire logic SUPPLY_LOW_I,
    input wire logic TEMP_WARN_I,
    input wire logic TEMP_SHUT_I,
    // power stage
    output logic [3:0] HS_ON_O,
    output logic [3:0] LS_ON_O,
    output logic [3:0] PULLDOWN_O,
    // ahb-lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic HREADYOUT_O,
    output logic [31:0] HRDATA_O,
    output logic HRESP_O
);
    // values the logic cannot serve are refused at elaboration
    if (NUM_HB != 4) begin : g_bad_hb
        $error("bgp_ctrl serves exactly four half bridges");
    end
    if (MAX_ON < 2 || MAX_ON > 65535) begin : g_bad_on
        $error("MAX_ON out of range");
    end

    bgp_pkg::bgp_mode_t mode;
    logic ready;
    logic [7:0] dead;
    logic [7:0] rech_len;
    logic pr1_q;
    logic pr2_q;
    logic [3:0] oc_latch;
    logic [3:0] cbc_off;
    logic [3:0] cbc_ls;
    logic [3:0] pwm_q;
    logic [3:0] rech_act;
    logic [7:0] rech_cnt [4];
    logic [15:0] on_cnt [4];
    logic therm_latch;
    logic seen1;
    logic seen2;
    logic [3:0] pwm_eff;
    logic [3:0] period_start;
    logic [3:0] trip_hs;
    logic [3:0] trip_ls;
    logic [3:0] trip_short;
    logic [3:0] pair_rst_n;
    logic [3:0] pair_rise;
    logic [3:0] want_hs;
    logic [3:0] want_ls;
    logic [3:0] hs_drv;
    logic [3:0] ls_drv;
    logic rise1;
    logic rise2;
    logic latch_mode;
    logic paired;

    // partner bridge whose trips are shared in parallel mode
    function automatic int partner(input int i);
        return i ^ 1;
    endfunction

    // strap is caught one edge after reset release
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            mode <= bgp_pkg::BGP_MODE_INDEP_CBC;
            ready <= 1'b0;
        end else if (!ready) begin
            mode <= bgp_pkg::bgp_mode_t'(MODE_I);
            ready <= 1'b1;
        end
    end

    assign latch_mode = (mode == bgp_pkg::BGP_MODE_INDEP_LATCH);
    assign paired = (mode == bgp_pkg::BGP_MODE_PARALLEL);
    assign rise1 = PAIR_ONE_RESET_N_I && !pr1_q;
    assign rise2 = PAIR_TWO_RESET_N_I && !pr2_q;
    assign pair_rst_n = {PAIR_TWO_RESET_N_I, PAIR_TWO_RESET_N_I,
                         PAIR_ONE_RESET_N_I, PAIR_ONE_RESET_N_I};
    assign pair_rise = {rise2, rise2, rise1, rise1};

    // input to bridge mapping
    always_comb begin
        unique case (mode)
            bgp_pkg::BGP_MODE_PARALLEL:
                pwm_eff = {PWM_I[1], PWM_I[1], PWM_I[0], PWM_I[0]};
            bgp_pkg::BGP_MODE_SINGLE:
                pwm_eff = {!PWM_I[2], PWM_I[2], !PWM_I[0], PWM_I[0]};
            default:
                pwm_eff = PWM_I;
        endcase
    end

    // trips; paralleled bridges share them so they stay in step
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            trip_hs[i] = OC_HS_I[i] || (paired && OC_HS_I[partner(i)]);
            trip_ls[i] = OC_LS_I[i] || (paired && OC_LS_I[partner(i)]);
            trip_short[i] = SHORT_I[i] || (paired && SHORT_I[partner(i)]);
        end
    end

    assign period_start = pwm_eff & ~pwm_q;

    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            pwm_q <= 4'h0;
            pr1_q <= 1'b0;
            pr2_q <= 1'b0;
        end else begin
            pwm_q <= pwm_eff;
            pr1_q <= PAIR_ONE_RESET_N_I;
            pr2_q <= PAIR_TWO_RESET_N_I;
        end
    end

    // per bridge latched shutdown; a new trip wins over the clearing edge
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            oc_latch <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (latch_mode && (trip_hs[i] || trip_ls[i])) begin
                    oc_latch[i] <= 1'b1;
                end else if (!latch_mode && trip_short[i]) begin
                    oc_latch[i] <= 1'b1;
                end else if (pair_rise[i]) begin
                    oc_latch[i] <= 1'b0;
                end
            end
        end
    end

    // cycle limiting holds until the bridge's next period starts
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            cbc_off <= 4'h0;
            cbc_ls <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (!latch_mode && trip_ls[i]) begin
                    cbc_off[i] <= 1'b1;
                end else if (period_start[i] || latch_mode) begin
                    cbc_off[i] <= 1'b0;
                end
                if (!latch_mode && trip_hs[i]) begin
                    cbc_ls[i] <= 1'b1;
                end else if (period_start[i] || latch_mode) begin
                    cbc_ls[i] <= 1'b0;
                end
            end
        end
    end

    // thermal latch needs a rising edge on both pair resets
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            therm_latch <= 1'b0;
            seen1 <= 1'b0;
            seen2 <= 1'b0;
        end else if (TEMP_SHUT_I) begin
            therm_latch <= 1'b1;
            seen1 <= 1'b0;
            seen2 <= 1'b0;
        end else if (therm_latch) begin
            if ((seen1 || rise1) && (seen2 || rise2)) begin
                therm_latch <= 1'b0;
                seen1 <= 1'b0;
                seen2 <= 1'b0;
            end else begin
                seen1 <= seen1 || rise1;
                seen2 <= seen2 || rise2;
            end
        end
    end

    // bootstrap recharge: low side pulses while the cap is low
    // or the high side has been on too long to refresh it
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rech_act <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                rech_cnt[i] <= 8'h00;
                on_cnt[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (rech_act[i]) begin
                    on_cnt[i] <= 16'h0000;
                    if (rech_cnt[i] == 8'h00) begin
                        rech_act[i] <= 1'b0;
                    end else begin
                        rech_cnt[i] <= rech_cnt[i] - 8'h01;
                    end
                end else if (want_hs[i] && (BOOTSTRAP_LOW_I[i] ||
                             on_cnt[i] >= 16'(MAX_ON - 1))) begin
                    rech_act[i] <= 1'b1;
                    rech_cnt[i] <= rech_len;
                    on_cnt[i] <= 16'h0000;
                end else if (want_hs[i]) begin
                    on_cnt[i] <= on_cnt[i] + 16'h0001;
                end else begin
                    on_cnt[i] <= 16'h0000;
                end
            end
        end
    end

    // gate request per bridge, protection first
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            want_hs[i] = 1'b0;
            want_ls[i] = 1'b0;
            if (!ready || SUPPLY_LOW_I || therm_latch || oc_latch[i] ||
                !pair_rst_n[i]) begin
                // all off
            end else if (cbc_off[i]) begin
                // both off for the rest of the period
            end else if (cbc_ls[i] || rech_act[i]) begin
                want_ls[i] = 1'b1;
            end else begin
                want_hs[i] = pwm_eff[i];
                want_ls[i] = !pwm_eff[i];
            end
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_hb
        bgp_half_bridge u_hb (
            .clk_i(SYS_CLK_I),
            .rst_i(RESET_I),
            .want_hs_i(want_hs[g]),
            .want_ls_i(want_ls[g]),
            .dead_i(dead),
            .hs_o(hs_drv[g]),
            .ls_o(ls_drv[g])
        );
    end
    assign HS_ON_O = hs_drv;
    assign LS_ON_O = ls_drv;

    // status pins and pulldown
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            FAULT_N_O <= 1'b1;
            THERMAL_WARNING_N_O <= 1'b1;
            PULLDOWN_O <= 4'h0;
        end else begin
            FAULT_N_O <= !(SUPPLY_LOW_I || therm_latch || (|oc_latch));
            THERMAL_WARNING_N_O <= !TEMP_WARN_I;
            PULLDOWN_O <= ~pair_rst_n;
        end
    end

    // ahb-lite slave, zero wait states
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] status;
    logic addr_ok;

    assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];
    assign status = {12'h000, rech_act, cbc_off | cbc_ls, 2'h0, mode, ready, TEMP_WARN_I,
                     SUPPLY_LOW_I, therm_latch, oc_latch};

    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            HRDATA_O <= 32'h0000_0000;
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end else begin
            wr_pend <= addr_ok && HWRITE_I;
            wr_addr <= HADDR_I[7:0];
            if (addr_ok && !HWRITE_I) begin
                unique case (HADDR_I[7:0])
                    bgp_pkg::CTRL_OFS: HRDATA_O <= {16'h0000, rech_len, dead};
                    bgp_pkg::STATUS_OFS: HRDATA_O <= status;
                    default: HRDATA_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control register steers gap and recharge length
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            dead <= bgp_pkg::DEAD_RST;
            rech_len <= bgp_pkg::RECH_RST;
        end else if (wr_pend && wr_addr == bgp_pkg::CTRL_OFS) begin
            dead <= HWDATA_I[bgp_pkg::CTRL_DEAD_LSB +: 8];
            rech_len <= HWDATA_I[bgp_pkg::CTRL_RECH_LSB +: 8];
        end
    end
endmodule
`default_nettype wire

// ### bgp_ctrl_chk.sv
// assertions on the gate and status ports of the bridge controller
`timescale 1ns/1ps
`default_nettype none
module bgp_ctrl_chk #(
    parameter int NUM_HB = 4,
    parameter int MAX_ON = bgp_pkg::MAX_ON_CYCLES
) (
    // controller side
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic [3:0] PWM_I,
    input wire logic PAIR_ONE_RESET_N_I,
    input wire logic PAIR_TWO_RESET_N_I,
    input wire logic FAULT_N_O,
    input wire logic THERMAL_WARNING_N_O,
    // comparators
    input wire logic [3:0] OC_HS_I,
    input wire logic [3:0] OC_LS_I,
    input wire logic SUPPLY_LOW_I,
    input wire logic TEMP_WARN_I,
    input wire logic TEMP_SHUT_I,
    // power stage
    input wire logic [3:0] HS_ON_O,
    input wire logic [3:0] LS_ON_O,
    input wire logic [3:0] PULLDOWN_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    wire logic [3:0] on = HS_ON_O | LS_ON_O;
    property p_overlap; (HS_ON_O & LS_ON_O) == 4'h0; endproperty
    a_overlap: assert property (p_overlap) else $error("gate overlap");
    property p_pair; (!PAIR_ONE_RESET_N_I |=> on[1:0] == 2'h0)
        and (!PAIR_TWO_RESET_N_I |=> on[3:2] == 2'h0); endproperty
    a_pair: assert property (p_pair) else $error("pair reset not off");
    // reset still sampled high at the release edge, so that launch is skipped
    property p_pulldown; !RESET_I |=> PULLDOWN_O ==
        {{2{!$past(PAIR_TWO_RESET_N_I)}}, {2{!$past(PAIR_ONE_RESET_N_I)}}}; endproperty
    a_pulldown: assert property (p_pulldown) else $error("pulldown wrong");
    property p_supply; !RESET_I && SUPPLY_LOW_I |=> on == 4'h0 && !FAULT_N_O; endproperty
    a_supply: assert property (p_supply) else $error("supply low not off");
    property p_warn; !RESET_I |=> THERMAL_WARNING_N_O == !$past(TEMP_WARN_I); endproperty
    a_warn: assert property (p_warn) else $error("warning wrong");
    // latch takes one edge, the gate stage a second one
    property p_tshut; !RESET_I && TEMP_SHUT_I |-> ##2 (on == 4'h0 && !FAULT_N_O); endproperty
    a_tshut: assert property (p_tshut) else $error("thermal not off");
    property p_tlatch; $fell(TEMP_SHUT_I) && PAIR_ONE_RESET_N_I && PAIR_TWO_RESET_N_I
        |=> (on == 4'h0 && !FAULT_N_O) [*2]; endproperty
    a_tlatch: assert property (p_tlatch) else $error("thermal not held");
    property p_ls_trip; OC_LS_I[0] |-> ##2 on[0] == 1'b0; endproperty
    a_ls_trip: assert property (p_ls_trip) else $error("low trip not off");
    property p_hs_trip; OC_HS_I[1] |-> ##2 !HS_ON_O[1]; endproperty
    a_hs_trip: assert property (p_hs_trip) else $error("high trip not off");
    property p_period; OC_LS_I[0] ##1 (!$rose(PWM_I[0])) [*3] |-> on[0] == 1'b0; endproperty
    a_period: assert property (p_period) else $error("trip not held");
endmodule
`default_nettype wire

// ### bgp_pwm_model.sv
// pwm controller model driving the four pwm inputs
`timescale 1ns/1ps
`default_nettype none
module bgp_pwm_model (
    // control from the bench
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [3:0] lvl_i,
    input wire logic [7:0] period_i,
    input wire logic [7:0] high_i,
    // pwm pins
    output logic [3:0] pwm_o
);
    logic [7:0] cnt = 8'h0;
    logic [7:0] hi;
    // low phase long enough for a recharge pulse
    assign hi = (high_i + 8'h6 > period_i) ? period_i - 8'h6 : high_i;
    always @(posedge clk_i) begin
        cnt <= (cnt + 8'h1 >= period_i) ? 8'h0 : cnt + 8'h1;
        pwm_o <= run_i ? {4{cnt < hi}} : lvl_i;
    end
endmodule
`default_nettype wire

// ### bgp_ctrl_tb.sv
// self-checking bench for the bridge gate protection block
`timescale 1ns/1ps
`default_nettype none
module bgp_ctrl_tb;
    localparam int MAX_ON = 50;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sup = 1'b1;
    logic p1n = 1'b0, p2n = 1'b0, tw = 1'b0, ts = 1'b0, run = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] mode = 2'h0, htrans = 2'h0;
    logic [3:0] oc_hs = 4'h0, oc_ls = 4'h0, shrt = 4'h0, bst = 4'h0, lvl = 4'h0;
    logic [7:0] per = 8'h28, hi = 8'h14;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    wire logic [3:0] pwm, hs, ls, pd;
    wire logic fault_n, warn_n, hro, hresp;
    wire logic [31:0] hrd;
    int n_errors = 0;
    int n_compared = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    bgp_pwm_model u_bgp_pwm_model (.clk_i(clk), .run_i(run), .lvl_i(lvl), .period_i(per),
        .high_i(hi), .pwm_o(pwm));
    bgp_ctrl #(.MAX_ON(MAX_ON)) u_bgp_ctrl (.SYS_CLK_I(clk), .RESET_I(rst), .PWM_I(pwm),
        .PAIR_ONE_RESET_N_I(p1n), .PAIR_TWO_RESET_N_I(p2n), .MODE_I(mode),
        .FAULT_N_O(fault_n), .THERMAL_WARNING_N_O(warn_n), .OC_HS_I(oc_hs), .OC_LS_I(oc_ls),
        .SHORT_I(shrt), .BOOTSTRAP_LOW_I(bst), .SUPPLY_LOW_I(sup), .TEMP_WARN_I(tw),
        .TEMP_SHUT_I(ts), .HS_ON_O(hs), .LS_ON_O(ls), .PULLDOWN_O(pd), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
        .HWDATA_I(hwdata), .HREADY_I(hro), .HREADYOUT_O(hro), .HRDATA_O(hrd), .HRESP_O(hresp));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task done(input string s); $display("test %s finished", s); endtask
    task cyc(input int n); repeat (n) @(posedge clk); endtask
    // bounded wait for the slave's ready
    task rdy;
        for (int k = 0; k < 20; k++) begin
            @(posedge clk);
            if (hro === 1'b1) return;
        end
        n_errors++;
        conclude();
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rd = hrd;
    endtask
    task restart(input logic [1:0] m);
        rst <= 1'b1;
        mode <= m;
        {p1n, p2n, run, lvl} <= 7'h0;
        cyc(4);
        rst <= 1'b0;
        // pair resets low a while so pulldown shows
        cyc(2);
        {p1n, p2n} <= 2'h3;
        cyc(2);
    endtask
    task toggle(input logic one, input logic two);
        {p1n, p2n} <= {~one, ~two};
        cyc(2);
        {p1n, p2n} <= 2'h3;
        cyc(10);
    endtask
    // new period from all low so on-time counts restart
    task fresh(input logic [3:0] p);
        lvl <= 4'h0;
        cyc(3);
        lvl <= p;
        cyc(10);
    endtask
    function logic [3:0] mapped(input logic [1:0] m, input logic [3:0] p);
        case (m)
            2'h2: mapped = {p[1], p[1], p[0], p[0]};
            2'h3: mapped = {~p[2], p[2], ~p[0], p[0]};
            default: mapped = p;
        endcase
    endfunction
    initial begin
        int c;
        logic [3:0] p;
        logic [7:0] d;
        void'($urandom(32'hd5fb));
        cyc(3);
        chk({hs, ls, pd, fault_n, warn_n, hro, hresp}, 16'he);
        chk(hrd, 32'h0);
        restart(2'h0);
        lvl <= 4'hf;
        cyc(10);
        chk({hs, ls, fault_n}, 9'h0);
        sup <= 1'b0;
        cyc(12);
        chk({hs, ls, fault_n}, 9'h1e1);
        done("supply");
        for (int m = 0; m < 4; m++) begin
            restart(2'(m));
            bus(1'b0, bgp_pkg::STATUS_OFS, 32'h0);
            chk(rd[9:7], {2'(m), 1'b1});
            repeat (3) begin
                p = 4'($urandom);
                lvl <= p;
                cyc(12);
                chk({hs, ls}, {mapped(2'(m), p), ~mapped(2'(m), p)});
            end
        end
        done("modes");
        bus(1'b0, bgp_pkg::CTRL_OFS, 32'h0);
        chk(rd, {16'h0, bgp_pkg::RECH_RST, bgp_pkg::DEAD_RST});
        d = 8'($urandom_range(4, 1));
        bus(1'b1, bgp_pkg::CTRL_OFS, {16'h0, bgp_pkg::RECH_RST, d});
        bus(1'b1, 8'h10, 32'hffff_ffff);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, bgp_pkg::CTRL_OFS, 32'h0);
        chk(rd[7:0], d);
        fresh(4'h0);
        lvl <= 4'h1;
        c = 0;
        for (int k = 0; k < 40 && hs[0] !== 1'b1; k++) begin
            cyc(1);
            c += int'(hs[0] !== 1'b1 && ls[0] !== 1'b1);
        end
        chk(32'(c >= int'(d)), 32'h1);
        chk(hs[0], 1'b1);
        done("bus and gap");
        restart(2'h0);
        fresh(4'hf);
        oc_ls <= 4'h1;
        cyc(1);
        oc_ls <= 4'h0;
        cyc(3);
        chk({hs, ls, fault_n}, 9'h1c1);
        lvl <= 4'he;
        cyc(2);
        lvl <= 4'hf;
        cyc(10);
        chk(hs, 4'hf);
        oc_hs <= 4'h2;
        cyc(1);
        oc_hs <= 4'h0;
        cyc(8);
        chk({hs, ls}, 8'hd2);
        fresh(4'hf);
        shrt <= 4'h4;
        cyc(1);
        shrt <= 4'h0;
        cyc(12);
        chk({hs, fault_n, warn_n}, 6'h2d);
        toggle(1'b0, 1'b1);
        chk({hs[3:2], fault_n}, 3'h7);
        done("cycle limit");
        restart(2'h1);
        fresh(4'hf);
        oc_ls <= 4'h1;
        cyc(1);
        oc_ls <= 4'h0;
        lvl <= 4'he;
        cyc(2);
        lvl <= 4'hf;
        cyc(10);
        chk({hs, fault_n}, 5'h1c);
        toggle(1'b1, 1'b0);
        chk({hs, fault_n}, 5'h1f);
        done("latching");
        fresh(4'hf);
        tw <= 1'b1;
        cyc(3);
        chk({fault_n, warn_n}, 2'h2);
        ts <= 1'b1;
        cyc(2);
        ts <= 1'b0;
        cyc(2);
        chk({hs, ls, fault_n, warn_n}, 10'h0);
        tw <= 1'b0;
        toggle(1'b1, 1'b0);
        chk({hs, fault_n}, 5'h0);
        toggle(1'b0, 1'b1);
        chk({fault_n, warn_n}, 2'h3);
        done("thermal");
        fresh(4'hf);
        bst <= 4'h8;
        for (int k = 0; k < 20 && ls[3] !== 1'b1; k++) cyc(1);
        chk({ls[3], hs[0]}, 2'h3);
        bst <= 4'h0;
        for (int k = 0; k < 80 && ls[0] !== 1'b1; k++) cyc(1);
        chk(ls[0], 1'b1);
        done("bootstrap");
        run <= 1'b1;
        repeat (4) begin
            per <= 8'($urandom_range(60, 20));
            hi <= 8'($urandom_range(50, 2));
            cyc(200);
        end
        chk(fault_n, 1'b1);
        done("random pwm");
        conclude();
    end
endmodule
bind bgp_ctrl bgp_ctrl_chk #(.NUM_HB(NUM_HB), .MAX_ON(MAX_ON)) u_chk (.SYS_CLK_I, .RESET_I,
    .PWM_I, .PAIR_ONE_RESET_N_I, .PAIR_TWO_RESET_N_I, .FAULT_N_O, .THERMAL_WARNING_N_O,
    .OC_HS_I, .OC_LS_I, .SUPPLY_LOW_I, .TEMP_WARN_I, .TEMP_SHUT_I, .HS_ON_O, .LS_ON_O,
    .PULLDOWN_O);
`default_nettype wire
